/* File: rtl/sar_adc_sequencer.sv */
// Behaviour
// - Enable: software starts now, hardware waits
// - Sample fixed interval, then hold until done
// - Trial bit 9 first, DAC half scale
// - Bit 8 trial at three or one quarter
// - Ten bits, store result, then interrupt
// - Kind bit picks software or hardware trigger
// - Hardware source: 00 pin, 01/10 timers
// - Software continuous repeats, one-shot stops
// - Busy flag set when conversion starts
// - Software: config write restarts conversion
// - Edge field picks rising, falling, both
// - Hardware: store, interrupt, await next trigger
// - Hardware: busy low while waiting trigger
// - Hardware: trigger during conversion restarts it
// - External: config write waits after finishing
// - Timer: config write stops, awaits trigger
// - Timer: rising edge of selected match
// - Mode field selects sequencing kind
// - Continuous select: one channel, every interrupt
// - Continuous scan: 0..sel, interrupt, repeat
// - Result high ten bits, low six zero
// - One-shot scan: 0..sel once, then stop
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"
module sar_adc_sequencer
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        conv_enable_bit,
   input  wire logic        trigger_kind_bit,
   input  wire logic        hw_trigger_sel_hi,
   input  wire logic        hw_trigger_sel_lo,
   input  wire logic        op_mode_hi,
   input  wire logic        op_mode_lo,
   input  wire logic        edge_sel_hi,
   input  wire logic        edge_sel_lo,
   input  wire logic [4:0]  channel_select_reg,
   input  wire logic        cfg_write,
   input  wire logic        ext_trigger_pin,
   input  wire logic        timer_match_evt0,
   input  wire logic        timer_match_evt1,
   input  wire logic        comp_in_higher,
   input  wire logic [4:0]  result_read_ch,
   output logic      [9:0]  dac_code,
   output logic      [4:0]  mux_channel,
   output logic             sample_en,
   output logic             conv_busy_flag,
   output logic             conv_end_irq,
   output logic      [15:0] channel_result_reg,
   output logic      [7:0]  channel_result_byte
);
   typedef struct packed
   {
      sar_adc_pkg::seq_state_type st_r;
      logic [9:0]                 approx_shift_reg;
      logic [9:0]                 trial_r;
      logic [4:0]                 ch_r;
      logic [5:0]                 cnt_r;
      logic                       en_r;
      logic                       irq_r;
      logic                       wr_r;
      logic [9:0]                 wdata_r;
      logic [4:0]                 wch_r;
      logic                       after_wr_r;
   } seq_regs_type;

   seq_regs_type s_r;
   seq_regs_type s_nxt;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic       ext_rise;
   logic       ext_fall;
   logic       t0_rise;
   logic       t1_rise;
   logic [1:0] hw_sel;
   logic [1:0] op_mode;
   logic [1:0] edge_sel;
   logic       hw_mode;
   logic       ext_mode;
   logic       hw_trig;
   logic       scan_mode;
   logic       cont_mode;
   logic [4:0] start_ch;
   logic [9:0] decided;
   logic       last_ch;

   edge_detect u_ext
   (
      .clock (clock),
      .rst_n (rst_n),
      .level (ext_trigger_pin),
      .rise  (ext_rise),
      .fall  (ext_fall)
   );

   edge_detect u_t0
   (
      .clock (clock),
      .rst_n (rst_n),
      .level (timer_match_evt0),
      .rise  (t0_rise),
      .fall  ()
   );

   edge_detect u_t1
   (
      .clock (clock),
      .rst_n (rst_n),
      .level (timer_match_evt1),
      .rise  (t1_rise),
      .fall  ()
   );

   result_mem u_mem
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .wr_en   (s_r.wr_r),
      .wr_ch   (s_r.wch_r),
      .wr_data (s_r.wdata_r),
      .rd_ch   (result_read_ch),
      .rd_word (channel_result_reg),
      .rd_byte (channel_result_byte)
   );

   assign hw_sel   = {hw_trigger_sel_hi, hw_trigger_sel_lo};
   assign op_mode  = {op_mode_hi, op_mode_lo};
   assign edge_sel = {edge_sel_hi, edge_sel_lo};
   assign hw_mode  = trigger_kind_bit;
   assign ext_mode = hw_mode && hw_sel == `HWTRIG_EXT;
   assign scan_mode = op_mode == `OPMODE_CONT_SCAN ||
                      op_mode == `OPMODE_ONCE_SCAN;
   assign cont_mode = op_mode == `OPMODE_CONT_SEL ||
                      op_mode == `OPMODE_CONT_SCAN;
   assign start_ch = scan_mode ? 5'h00 : channel_select_reg;
   assign last_ch  = !scan_mode || s_r.ch_r >= channel_select_reg;

   // Prohibited source code 11 never fires
   always_comb
   begin
      hw_trig = 1'b0;
      unique case (hw_sel)
         `HWTRIG_EXT:
         begin
            unique case (edge_sel)
               `EDGE_RISE: hw_trig = ext_rise;
               `EDGE_FALL: hw_trig = ext_fall;
               `EDGE_BOTH: hw_trig = ext_rise | ext_fall;
               default:    hw_trig = 1'b0;
            endcase
         end
         `HWTRIG_TMR0: hw_trig = t0_rise;
         `HWTRIG_TMR1: hw_trig = t1_rise;
         default:      hw_trig = 1'b0;
      endcase
   end

   // Comparator judges the current trial bit
   assign decided = comp_in_higher ? s_r.approx_shift_reg
                   : (s_r.approx_shift_reg & ~s_r.trial_r);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.en_r  = conv_enable_bit;
      s_nxt.irq_r = 1'b0;
      s_nxt.wr_r  = 1'b0;
      if (s_r.st_r == sar_adc_pkg::ST_IDLE)
         s_nxt.after_wr_r = 1'b0;
      if (!conv_enable_bit)
      begin
         s_nxt.st_r = sar_adc_pkg::ST_IDLE;
      end
      else if (!s_r.en_r)
      begin
         // Rising enable
         s_nxt.after_wr_r = 1'b0;
         if (hw_mode)
            s_nxt.st_r = sar_adc_pkg::ST_WAIT;
         else
         begin
            s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
            s_nxt.ch_r = start_ch;
            s_nxt.cnt_r = 6'h00;
         end
      end
      else
      begin
         unique case (s_r.st_r)
            sar_adc_pkg::ST_IDLE: s_nxt.st_r = sar_adc_pkg::ST_IDLE;
            sar_adc_pkg::ST_WAIT:
            begin
               if (hw_trig)
               begin
                  // Stale write mark would cut the next scan short
                  s_nxt.after_wr_r = 1'b0;
                  s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
                  s_nxt.ch_r = start_ch;
                  s_nxt.cnt_r = 6'h00;
               end
            end
            sar_adc_pkg::ST_SAMPLE:
            begin
               // Track input, then hold through all trials
               s_nxt.cnt_r = s_r.cnt_r + 6'h01;
               if (s_r.cnt_r == 6'(`SAMPLE_CYCLES - 1))
               begin
                  s_nxt.st_r = sar_adc_pkg::ST_TRIAL;
                  s_nxt.approx_shift_reg = `SAR_MSB_VALUE;
                  s_nxt.trial_r = `SAR_MSB_VALUE;
               end
            end
            sar_adc_pkg::ST_TRIAL:
            begin
               if (s_r.trial_r != 10'h001)
               begin
                  s_nxt.trial_r = s_r.trial_r >> 1;
                  s_nxt.approx_shift_reg = decided | (s_r.trial_r >> 1);
               end
               else
               begin
                  s_nxt.approx_shift_reg = decided;
                  s_nxt.wr_r    = 1'b1;
                  s_nxt.wdata_r = decided;
                  s_nxt.wch_r   = s_r.ch_r;
                  s_nxt.irq_r   = last_ch;
                  s_nxt.cnt_r   = 6'h00;
                  if (hw_mode)
                  begin
                     if (!last_ch && !s_r.after_wr_r)
                     begin
                        s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
                        s_nxt.ch_r = s_r.ch_r + 5'h01;
                     end
                     else
                        s_nxt.st_r = sar_adc_pkg::ST_WAIT;
                     s_nxt.irq_r = last_ch || s_r.after_wr_r;
                  end
                  else if (!last_ch)
                  begin
                     s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
                     s_nxt.ch_r = s_r.ch_r + 5'h01;
                  end
                  else if (cont_mode)
                  begin
                     s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
                     s_nxt.ch_r = start_ch;
                  end
                  else
                     s_nxt.st_r = sar_adc_pkg::ST_IDLE;
               end
            end
            default:
            begin
               s_nxt.st_r = sar_adc_pkg::ST_IDLE;
            end
         endcase
         if (s_r.st_r == sar_adc_pkg::ST_SAMPLE ||
             s_r.st_r == sar_adc_pkg::ST_TRIAL)
         begin
            if (hw_mode && hw_trig)
            begin
               s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
               s_nxt.ch_r = start_ch;
               s_nxt.cnt_r = 6'h00;
               s_nxt.wr_r = 1'b0;
               s_nxt.irq_r = 1'b0;
               s_nxt.after_wr_r = 1'b0;
            end
            else if (cfg_write && !hw_mode)
            begin
               s_nxt.st_r = sar_adc_pkg::ST_SAMPLE;
               s_nxt.ch_r = start_ch;
               s_nxt.cnt_r = 6'h00;
               s_nxt.wr_r = 1'b0;
               s_nxt.irq_r = 1'b0;
            end
            else if (cfg_write && ext_mode)
               s_nxt.after_wr_r = 1'b1;
            else if (cfg_write && hw_mode)
            begin
               s_nxt.st_r = sar_adc_pkg::ST_WAIT;
               s_nxt.wr_r = 1'b0;
               s_nxt.irq_r = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.st_r <= sar_adc_pkg::ST_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   assign dac_code    = s_r.approx_shift_reg;
   assign mux_channel = s_r.ch_r;
   assign sample_en   = s_r.st_r == sar_adc_pkg::ST_SAMPLE;
   // Busy only while sampling or trialing
   assign conv_busy_flag = s_r.st_r == sar_adc_pkg::ST_SAMPLE ||
                           s_r.st_r == sar_adc_pkg::ST_TRIAL;
   assign conv_end_irq = s_r.irq_r;

   a_idle_not_busy: assert property (
      !s_r.en_r |-> !conv_busy_flag) else $error("busy while disabled");
   a_sw_start_now: assert property (
      conv_enable_bit && !s_r.en_r && !hw_mode |=> conv_busy_flag)
      else $error("software start late");
   a_hw_waits: assert property (
      conv_enable_bit && s_r.st_r == sar_adc_pkg::ST_WAIT && !hw_trig
      |=> !conv_busy_flag) else $error("busy while waiting");
   a_msb_first: assert property (
      s_r.st_r == sar_adc_pkg::ST_TRIAL && s_r.trial_r == 10'h200 &&
      s_nxt.st_r == sar_adc_pkg::ST_TRIAL
      |=> dac_code == {$past(comp_in_higher), 9'h100})
      else $error("bit 8 trial wrong");
   a_trial_start: assert property (
      $rose(s_r.st_r == sar_adc_pkg::ST_TRIAL)
      |-> s_r.trial_r == 10'h200 && dac_code == 10'h200)
      else $error("trial not at bit 9");
   a_irq_with_store: assert property (
      conv_end_irq |-> s_r.wr_r) else $error("irq without store");
   a_hw_trig_busy: assert property (
      conv_enable_bit && s_r.en_r && hw_mode && hw_trig |=> sample_en)
      else $error("trigger ignored");
   a_tmr_cfg_stop: assert property (
      conv_enable_bit && s_r.en_r && hw_mode && !ext_mode && !hw_trig
      && cfg_write && conv_busy_flag |=> !conv_busy_flag)
      else $error("timer write no stop");
   a_sw_cfg_restart: assert property (
      conv_enable_bit && s_r.en_r && !hw_mode && cfg_write && conv_busy_flag
      |=> sample_en && s_r.cnt_r == 6'h00) else $error("no restart");
   c_sw_done: cover property (conv_end_irq && !hw_mode);
   c_hw_done: cover property (conv_end_irq && hw_mode);
   c_scan_step: cover property (s_r.wr_r && scan_mode && !conv_end_irq);
endmodule
`default_nettype wire

/* File: rtl/sar_adc_consts.svh */
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define RES_BITS          10
`define CH_COUNT          24
`define CH_MAX            5'h17
`define SAMPLE_TIME_NS    500
`define CLOCK_PERIOD_NS   10
`define SAMPLE_CYCLES     ((`SAMPLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SAR_MSB_VALUE     10'h200
`define OPMODE_CONT_SEL   2'h0
`define OPMODE_CONT_SCAN  2'h1
`define OPMODE_ONCE_SEL   2'h2
`define OPMODE_ONCE_SCAN  2'h3
`define HWTRIG_EXT        2'h0
`define HWTRIG_TMR0       2'h1
`define HWTRIG_TMR1       2'h2
`define EDGE_RISE         2'h0
`define EDGE_FALL         2'h1
`define EDGE_BOTH         2'h2

`endif

/* File: rtl/sar_adc_pkg.sv */
package sar_adc_pkg;
   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'b0001,
      ST_WAIT   = 4'b0010,
      ST_SAMPLE = 4'b0100,
      ST_TRIAL  = 4'b1000
   } seq_state_type;
endpackage

/* File: rtl/edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_detect
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);
   typedef struct packed
   {
      logic prev_r;
   } edge_state_type;

   edge_state_type s_r;
   edge_state_type s_nxt;

   always_comb
   begin
      s_nxt.prev_r = level;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign rise = level & ~s_r.prev_r;
   assign fall = ~level & s_r.prev_r;
endmodule
`default_nettype wire

/* File: rtl/result_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"
module result_mem
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_ch,
   input  wire logic [9:0]  wr_data,
   input  wire logic [4:0]  rd_ch,
   output logic      [15:0] rd_word,
   output logic      [7:0]  rd_byte
);
   typedef struct packed
   {
      logic [`CH_COUNT-1:0][9:0] mem_r;
      logic [9:0]               rd_r;
   } mem_state_type;

   mem_state_type s_r;
   mem_state_type s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (wr_en && wr_ch <= `CH_MAX)
         s_nxt.mem_r[wr_ch] = wr_data;
      s_nxt.rd_r = (rd_ch <= `CH_MAX) ? s_r.mem_r[rd_ch] : 10'h000;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Result sits high, low six bits read zero
   assign rd_word = {s_r.rd_r, 6'h00};
   assign rd_byte = s_r.rd_r[9:2];
endmodule
`default_nettype wire

/* File: tb/comp_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module comp_dac_model
(
   input  wire logic             clock,
   input  wire logic             sample_en,
   input  wire logic [4:0]       mux_channel,
   input  wire logic [9:0]       dac_code,
   input  wire logic [23:0][9:0] vin,
   output logic                  comp_in_higher
);
   logic [9:0] held_r;

   // Track only while sampling; trials see the held value
   always_ff @(posedge clock)
      if (sample_en && mux_channel < 5'h18)
         held_r <= vin[mux_channel];
   assign comp_in_higher = (held_r >= dac_code);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic             clock = 1'b0;
   logic             rst_n = 1'b0;
   logic             en = 1'b0;
   logic             tk = 1'b0;
   logic             cfg = 1'b0;
   logic             pin = 1'b0;
   logic             t0 = 1'b0;
   logic             t1 = 1'b0;
   logic [1:0]       hs = 2'h0;
   logic [1:0]       op = 2'h0;
   logic [1:0]       es = 2'h0;
   logic [4:0]       sel = 5'h00;
   logic [4:0]       rch = 5'h00;
   logic [23:0][9:0] vin = '0;
   logic             comp;
   logic             samp;
   logic             busy;
   logic             irq;
   logic [9:0]       dac;
   logic [4:0]       mux;
   logic [15:0]      rword;
   logic [7:0]       rbyte;
   logic [9:0]       exp_res [24];
   int               n_fail = 0;
   int               n_compared = 0;
   int               n;

   always #5 clock = ~clock;

   sar_adc_sequencer i_sar_adc_sequencer
   (
      .clock(clock), .rst_n(rst_n), .conv_enable_bit(en),
      .trigger_kind_bit(tk), .hw_trigger_sel_hi(hs[1]),
      .hw_trigger_sel_lo(hs[0]), .op_mode_hi(op[1]), .op_mode_lo(op[0]),
      .edge_sel_hi(es[1]), .edge_sel_lo(es[0]), .channel_select_reg(sel),
      .cfg_write(cfg), .ext_trigger_pin(pin), .timer_match_evt0(t0),
      .timer_match_evt1(t1), .comp_in_higher(comp), .result_read_ch(rch),
      .dac_code(dac), .mux_channel(mux), .sample_en(samp),
      .conv_busy_flag(busy), .conv_end_irq(irq),
      .channel_result_reg(rword), .channel_result_byte(rbyte)
   );

   comp_dac_model i_comp_dac_model
   (
      .clock(clock), .sample_en(samp), .mux_channel(mux), .dac_code(dac),
      .vin(vin), .comp_in_higher(comp)
   );

   task automatic give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] expd);
      n_compared++;
      if (seen !== expd)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask

   // Bounded wait; n is -1 when no pulse came
   task automatic wait_irq(input int lim);
      n = 0;
      do
      begin
         tick(1);
         n++;
      end
      while (irq !== 1'b1 && n < lim);
      if (irq !== 1'b1)
         n = -1;
   endtask

   task automatic quiet(input int k);
      n = 0;
      repeat (k)
      begin
         tick(1);
         if (irq === 1'b1)
            n++;
      end
   endtask

   // Enable low for three edges so the rise is always seen
   task automatic setup(input logic k, input logic [1:0] h,
                        input logic [1:0] o, input logic [1:0] e,
                        input logic [4:0] s);
      @(posedge clock);
      en <= 1'b0;
      tk <= k;
      hs <= h;
      op <= o;
      es <= e;
      sel <= s;
      tick(2);
      @(posedge clock);
      en <= 1'b1;
   endtask

   task automatic store_read(input int lo, input int hi);
      for (int i = lo; i <= hi; i++)
      begin
         exp_res[i] = vin[i];
         @(posedge clock);
         rch <= i[4:0];
         tick(2);
         check(rword, {exp_res[i], 6'h00});
         check({8'h00, rbyte}, {8'h00, exp_res[i][9:2]});
      end
   endtask

   task automatic pulse_cfg;
      @(posedge clock);
      cfg <= 1'b1;
      @(posedge clock);
      cfg <= 1'b0;
   endtask

   task automatic trig(input int w, input logic lvl);
      @(posedge clock);
      case (w)
         0: pin <= lvl;
         1: t0 <= lvl;
         default: t1 <= lvl;
      endcase
   endtask

   task automatic hw_evt(input int w, input logic lvl, input logic go);
      trig(w, lvl);
      tick(6);
      check({15'h0, busy}, {15'h0, go});
      if (go)
      begin
         wait_irq(100);
         check({15'h0, n > 0}, 16'h0001);
         tick(3);
         check({15'h0, busy}, 16'h0000);
      end
   endtask

   task automatic stop_check;
      @(posedge clock);
      en <= 1'b0;
      tick(2);
      check({15'h0, busy}, 16'h0000);
      quiet(100);
      check(n[15:0], 16'h0000);
   endtask

   task automatic sw_one(input int ch);
      setup(1'b0, 2'h0, 2'h2, 2'h0, ch[4:0]);
      tick(1);
      check({11'h0, mux}, {11'h0, ch[4:0]});
      check({14'h0, samp, busy}, 16'h0003);
      tick(50);
      check({6'h0, dac}, 16'h0200);
      tick(1);
      check({14'h0, dac[9:8]}, {14'h0, vin[ch][9], 1'b1});
      wait_irq(20);
      check(n[15:0], 16'h0009);
      store_read(ch, ch);
      quiet(150);
      check(n[15:0], 16'h0000);
   endtask

   initial
   begin
      #300_000;
      n_fail++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(32'hfe7d_5b1f));
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 24; i++)
         vin[i] <= 10'($urandom);
      // Full scale and zero at the code boundaries
      vin[0] <= 10'h3ff;
      vin[1] <= 10'h000;
      sw_one(0);
      sw_one(1);
      sw_one(23);
      setup(1'b0, 2'h0, 2'h3, 2'h0, 5'h03);
      wait_irq(400);
      check({15'h0, n > 230}, 16'h0001);
      store_read(0, 3);
      quiet(150);
      check(n[15:0], 16'h0000);
      setup(1'b0, 2'h0, 2'h0, 2'h0, 5'h05);
      wait_irq(100);
      wait_irq(100);
      check({15'h0, n > 0}, 16'h0001);
      store_read(5, 5);
      stop_check();
      setup(1'b0, 2'h0, 2'h1, 2'h0, 5'h02);
      wait_irq(400);
      check({15'h0, n > 170}, 16'h0001);
      wait_irq(400);
      check({15'h0, n > 170}, 16'h0001);
      store_read(0, 2);
      stop_check();
      setup(1'b0, 2'h0, 2'h2, 2'h0, 5'h07);
      tick(30);
      pulse_cfg();
      wait_irq(100);
      check({15'h0, n > 40}, 16'h0001);
      for (int e = 0; e < 3; e++)
      begin
         setup(1'b1, 2'h0, {e[0], 1'b0}, e[1:0], 5'h04);
         tick(20);
         check({15'h0, busy}, 16'h0000);
         hw_evt(0, 1'b1, e != 1);
         hw_evt(0, 1'b0, e != 0);
         store_read(4, 4);
      end
      setup(1'b1, 2'h0, 2'h3, 2'h0, 5'h06);
      trig(0, 1'b1);
      tick(20);
      pulse_cfg();
      wait_irq(100);
      // Channel 0 runs to its end, a restart would come near 60
      check({15'h0, n > 0 && n < 50}, 16'h0001);
      tick(3);
      check({15'h0, busy}, 16'h0000);
      trig(0, 1'b0);
      trig(0, 1'b1);
      wait_irq(500);
      check({15'h0, n > 400}, 16'h0001);
      store_read(0, 6);
      trig(0, 1'b0);
      for (int h = 1; h < 3; h++)
      begin
         setup(1'b1, h[1:0], 2'h0, 2'h0, 5'h09);
         hw_evt(3 - h, 1'b1, 1'b0);
         trig(3 - h, 1'b0);
         trig(h, 1'b1);
         tick(20);
         trig(h, 1'b0);
         tick(2);
         trig(h, 1'b1);
         wait_irq(100);
         check({15'h0, n > 50}, 16'h0001);
         store_read(9, 9);
         trig(h, 1'b0);
         tick(2);
         trig(h, 1'b1);
         tick(20);
         pulse_cfg();
         tick(3);
         check({15'h0, busy}, 16'h0000);
         quiet(100);
         check(n[15:0], 16'h0000);
         trig(h, 1'b0);
      end
      setup(1'b1, 2'h3, 2'h0, 2'h0, 5'h02);
      for (int w = 0; w < 3; w++)
         hw_evt(w, 1'b1, 1'b0);
      // Edge code 11 selects no edge at all
      setup(1'b1, 2'h0, 2'h0, 2'h3, 5'h02);
      hw_evt(0, 1'b0, 1'b0);
      hw_evt(0, 1'b1, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
